// ==== logic/ncr_regs.svh ====
// Purpose: Register numbers, field positions, reset values and timing counts
// Assumes: Configuration accesses use register numbers, not byte addresses
// Notes: Included by the routing and register-bank design files of the node configuration block
`ifndef NCR_REGS_SVH
`define NCR_REGS_SVH
// Register numbers
`define NCR_A_DEV_ID 8'h00
`define NCR_A_SW_DESC 8'h01
`define NCR_A_SW_CFG 8'h04
`define NCR_A_NODE_ID 8'h05
`define NCR_A_CLKGEN 8'h06
`define NCR_A_SW_DIV 8'h07
`define NCR_A_REF_DIV 8'h08
`define NCR_A_SCAN_ID 8'h09
`define NCR_A_USERCODE 8'h0A
`define NCR_A_DIR_LO 8'h0C
`define NCR_A_DIR_HI 8'h0D
`define NCR_A_LINK_BASE 5'h04
// Switch configuration fields
`define NCR_CFG_WLOCK 31
`define NCR_CFG_CGLOCK 8
`define NCR_CFG_HDR 0
// Clock-generator settings fields
`define NCR_CG_NORST 31
`define NCR_CG_NOLOCK 30
`define NCR_CG_BYPASS 29
`define NCR_CG_JTAG 28
`define NCR_CG_WMASK 32'hF39F_FF7F
`define NCR_CG_RST 32'h0000_0000
// Link direction field and link count
`define NCR_LINK_DIR_HI 11
`define NCR_LINK_DIR_LO 8
`define NCR_NUM_LINKS 8
// Reset values
`define NCR_REF_DIV_RST 16'h0003
// Timing
`define NCR_CLK_NS 4
`define NCR_TILE_RST_NS 32
`define NCR_TILE_RST_CYC ((`NCR_TILE_RST_NS + `NCR_CLK_NS - 1) / `NCR_CLK_NS)
`endif

// ==== logic/ncr_pkg.sv ====
// Purpose: Types shared by the node configuration and routing files
// Assumes: Constants live in ncr_regs.svh
// Notes: Types only
package ncr_pkg;
	typedef logic [15:0] ncr_node_id_t;
	typedef logic [3:0] ncr_dir_t;
	typedef enum logic [1:0]
	{
		NCR_CG_IDLE = 2'b00,
		NCR_CG_RESET = 2'b01,
		NCR_CG_RELOCK = 2'b10
	} ncr_cg_state_t;
endpackage : ncr_pkg

// ==== logic/ncr_route.sv ====
// Purpose: Per-packet direction lookup and link eligibility
// Assumes: Destination and tables are stable in the cycle pkt_valid_i is high
// Notes: Result is registered, one cycle after the packet is offered
`timescale 1ns/1ps
`include "ncr_regs.svh"
module ncr_route
(
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Tables
	input wire ncr_pkg::ncr_node_id_t node_id_i,
	input wire logic [31:0] dir_lo_i,
	input wire logic [31:0] dir_hi_i,
	input wire logic [31:0] link_dirs_i,
	// Packet
	input wire logic pkt_valid_i,
	input wire ncr_pkg::ncr_node_id_t pkt_dest_i,
	// Result
	output logic route_valid_o,
	output logic route_local_o,
	output ncr_pkg::ncr_dir_t route_dir_o,
	output logic [`NCR_NUM_LINKS-1:0] link_eligible_o
);
	import ncr_pkg::*;

	ncr_node_id_t diff;
	logic [63:0] dirs_all;
	ncr_dir_t dir_tab [0:15];
	ncr_dir_t dir_next;
	logic local_next;
	logic [`NCR_NUM_LINKS-1:0] elig_next;

	// One nibble per mismatch position, 0..7 low word, 8..15 high word
	assign diff = pkt_dest_i ^ node_id_i;
	assign dirs_all = {dir_hi_i, dir_lo_i};
	assign local_next = (diff == 16'h0000);

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_tab
			assign dir_tab[gi] = dirs_all[4*gi +: 4];
		end
		for (gi = 0; gi < `NCR_NUM_LINKS; gi++)
		begin : g_link
			assign elig_next[gi] = pkt_valid_i && !local_next &&
				(dir_next == link_dirs_i[4*gi +: 4]);
		end
	endgenerate

	// Ascending scan so the highest differing bit wins
	always_comb
	begin
		dir_next = 4'h0;
		for (int k = 0; k < 16; k++)
			if (diff[k])
				dir_next = dir_tab[k];
	end

	// Registered result
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			route_valid_o <= 1'b0;
			route_local_o <= 1'b0;
			route_dir_o <= 4'h0;
			link_eligible_o <= '0;
		end
		else if (ce_i)
		begin
			route_valid_o <= pkt_valid_i;
			route_local_o <= pkt_valid_i && local_next;
			route_dir_o <= dir_next;
			link_eligible_o <= elig_next;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i || !ce_i);

	property p_route_top;
		pkt_valid_i && (pkt_dest_i[15] != node_id_i[15]) |=> route_dir_o == $past(dir_hi_i[31:28]);
	endproperty
	a_route_top: assert property (p_route_top) else $error("top mismatch dir wrong");

	property p_route_bit0;
		pkt_valid_i && (diff == 16'h0001) |=> route_dir_o == $past(dir_lo_i[3:0]) && !route_local_o;
	endproperty
	a_route_bit0: assert property (p_route_bit0) else $error("bit0 mismatch dir wrong");

	property p_route_local;
		pkt_valid_i && (pkt_dest_i == node_id_i) |=> route_local_o && link_eligible_o == '0;
	endproperty
	a_route_local: assert property (p_route_local) else $error("local packet not local");

	property p_route_link0;
		route_valid_o && !route_local_o && (route_dir_o == $past(link_dirs_i[3:0]))
			|-> link_eligible_o[0];
	endproperty
	a_route_link0: assert property (p_route_link0) else $error("link0 not eligible");

	c_route_remote: cover property (route_valid_o && !route_local_o && link_eligible_o != '0);
endmodule : ncr_route

// ==== logic/ncr_cfg.sv ====
// Purpose: Node configuration register bank with routing direction tables
// Assumes: Config port is single-cycle, reads answer on the next edge
// Notes: Identification values are parameters except boot straps and OTP code; the write lock clears only by reset, the clock-generator lock also by a write
`timescale 1ns/1ps
`include "ncr_regs.svh"
module ncr_cfg
#(
	parameter logic [7:0] SW_REVISION = 8'h01, // Arbitrary value
	parameter logic [7:0] SW_VERSION = 8'h01, // Arbitrary value
	parameter logic [7:0] NUM_SYS_LINKS = 8'h08,
	parameter logic [7:0] NUM_SW_PROCS = 8'h02,
	parameter logic [7:0] NUM_DEV_PROCS = 8'h02,
	parameter logic [31:0] SCAN_DEVICE_ID = 32'h0000_0001, // Arbitrary value
	parameter logic [17:0] METAL_ID = 18'h00001 // Arbitrary value
)
(
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Configuration access
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	// Straps and OTP
	input wire logic [7:0] boot_select_pins_i,
	input wire logic [13:0] otp_user_code_i,
	// Clock generator
	input wire logic cg_locked_i,
	output logic [2:0] cg_out_div_o,
	output logic [12:0] cg_fb_mul_o,
	output logic [6:0] cg_in_div_o,
	output logic cg_bypass_o,
	output logic cg_jtag_boot_o,
	output logic cg_busy_o,
	output logic tile_reset_o,
	// Switch settings
	output logic hdr_one_byte_o,
	output ncr_pkg::ncr_node_id_t node_id_o,
	output logic [15:0] sw_clk_div_o,
	output logic [15:0] ref_clk_div_o,
	// Packet routing
	input wire logic pkt_valid_i,
	input wire ncr_pkg::ncr_node_id_t pkt_dest_i,
	output logic route_valid_o,
	output logic route_local_o,
	output ncr_pkg::ncr_dir_t route_dir_o,
	output logic [`NCR_NUM_LINKS-1:0] link_eligible_o
);
	import ncr_pkg::*;

	logic [7:0] boot_reg;
	logic wlock_reg;
	logic cglock_reg;
	logic hdr_reg;
	ncr_node_id_t node_id_reg;
	logic [31:0] cg_reg;
	logic [15:0] sw_div_reg;
	logic [15:0] ref_div_reg;
	logic [31:0] dir_lo_reg;
	logic [31:0] dir_hi_reg;
	logic [31:0] link_dirs_reg;
	ncr_cg_state_t cg_state_reg;
	logic [3:0] cg_cnt_reg;
	logic [31:0] rd_next;
	logic wr_ok;
	logic cg_wr;
	logic link_hit;

	// Any accepted write; the lock also guards itself so it sticks until reset
	assign wr_ok = cfg_wr_i && ce_i && !wlock_reg;
	assign cg_wr = wr_ok && (cfg_addr_i == `NCR_A_CLKGEN) && !cglock_reg
		&& (cg_state_reg == NCR_CG_IDLE);
	assign link_hit = (cfg_addr_i[7:3] == `NCR_A_LINK_BASE);

	// Boot straps are caught while reset is held, then frozen
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
			boot_reg <= boot_select_pins_i;
	end

	// Switch configuration
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			wlock_reg <= 1'b0;
			cglock_reg <= 1'b0;
			hdr_reg <= 1'b0;
		end
		else if (wr_ok && cfg_addr_i == `NCR_A_SW_CFG)
		begin
			wlock_reg <= cfg_wdata_i[`NCR_CFG_WLOCK];
			cglock_reg <= cfg_wdata_i[`NCR_CFG_CGLOCK];
			hdr_reg <= cfg_wdata_i[`NCR_CFG_HDR];
		end
	end

	// Node identifier and clock dividers
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			node_id_reg <= 16'h0000;
			sw_div_reg <= 16'h0000;
			ref_div_reg <= `NCR_REF_DIV_RST;
		end
		else if (wr_ok)
		begin
			if (cfg_addr_i == `NCR_A_NODE_ID)
				node_id_reg <= cfg_wdata_i[15:0];
			if (cfg_addr_i == `NCR_A_SW_DIV)
				sw_div_reg <= cfg_wdata_i[15:0];
			if (cfg_addr_i == `NCR_A_REF_DIV)
				ref_div_reg <= cfg_wdata_i[15:0];
		end
	end

	// Clock-generator settings; reserved bits are never stored
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
			cg_reg <= `NCR_CG_RST;
		else if (cg_wr)
			cg_reg <= cfg_wdata_i & `NCR_CG_WMASK;
	end

	// Direction tables and per-link directions
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			dir_lo_reg <= 32'h0000_0000;
			dir_hi_reg <= 32'h0000_0000;
			link_dirs_reg <= 32'h0000_0000;
		end
		else if (wr_ok)
		begin
			if (cfg_addr_i == `NCR_A_DIR_LO)
				dir_lo_reg <= cfg_wdata_i;
			if (cfg_addr_i == `NCR_A_DIR_HI)
				dir_hi_reg <= cfg_wdata_i;
			if (link_hit)
				link_dirs_reg[4*cfg_addr_i[2:0] +: 4] <=
					cfg_wdata_i[`NCR_LINK_DIR_HI:`NCR_LINK_DIR_LO];
		end
	end

	// Tile reset then relock; further settings writes are refused until idle
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			cg_state_reg <= NCR_CG_IDLE;
			cg_cnt_reg <= 4'h0;
		end
		else if (ce_i)
		begin
			unique case (cg_state_reg)
				NCR_CG_IDLE:
				begin
					if (cg_wr && !cfg_wdata_i[`NCR_CG_NORST])
					begin
						cg_state_reg <= NCR_CG_RESET;
						cg_cnt_reg <= 4'(`NCR_TILE_RST_CYC - 1);
					end
					else if (cg_wr && !cfg_wdata_i[`NCR_CG_NOLOCK])
						cg_state_reg <= NCR_CG_RELOCK;
				end
				NCR_CG_RESET:
				begin
					if (cg_cnt_reg == 4'h0)
						cg_state_reg <= cg_reg[`NCR_CG_NOLOCK] ? NCR_CG_IDLE
							: NCR_CG_RELOCK;
					else
						cg_cnt_reg <= cg_cnt_reg - 4'h1;
				end
				NCR_CG_RELOCK:
				begin
					if (cg_locked_i)
						cg_state_reg <= NCR_CG_IDLE;
				end
				default:
					cg_state_reg <= NCR_CG_IDLE;
			endcase
		end
	end

	// Read multiplexer; unmapped numbers read as zero
	always_comb
	begin
		rd_next = 32'h0000_0000;
		case (cfg_addr_i)
			`NCR_A_DEV_ID: rd_next = {8'h00, boot_reg, SW_REVISION, SW_VERSION};
			`NCR_A_SW_DESC: rd_next = {8'h00, NUM_SYS_LINKS, NUM_SW_PROCS, NUM_DEV_PROCS};
			`NCR_A_SW_CFG: rd_next = {wlock_reg, 22'h000000, cglock_reg, 7'h00, hdr_reg};
			`NCR_A_NODE_ID: rd_next = {16'h0000, node_id_reg};
			`NCR_A_CLKGEN: rd_next = cg_reg;
			`NCR_A_SW_DIV: rd_next = {16'h0000, sw_div_reg};
			`NCR_A_REF_DIV: rd_next = {16'h0000, ref_div_reg};
			`NCR_A_SCAN_ID: rd_next = SCAN_DEVICE_ID;
			`NCR_A_USERCODE: rd_next = {otp_user_code_i, METAL_ID};
			`NCR_A_DIR_LO: rd_next = dir_lo_reg;
			`NCR_A_DIR_HI: rd_next = dir_hi_reg;
			default:
			begin
				if (link_hit)
					rd_next[`NCR_LINK_DIR_HI:`NCR_LINK_DIR_LO] =
						link_dirs_reg[4*cfg_addr_i[2:0] +: 4];
			end
		endcase
	end

	// Read answer, held until the next read
	always_ff @(posedge clock_i)
	begin
		if (!rstn_i)
		begin
			cfg_rdata_o <= 32'h0000_0000;
			cfg_rvalid_o <= 1'b0;
		end
		else if (ce_i)
		begin
			cfg_rvalid_o <= cfg_rd_i;
			if (cfg_rd_i)
				cfg_rdata_o <= rd_next;
		end
	end

	// Settings driven from registers
	assign hdr_one_byte_o = hdr_reg;
	assign node_id_o = node_id_reg;
	assign sw_clk_div_o = sw_div_reg;
	assign ref_clk_div_o = ref_div_reg;
	assign cg_out_div_o = cg_reg[25:23];
	assign cg_fb_mul_o = cg_reg[20:8];
	assign cg_in_div_o = cg_reg[6:0];
	assign cg_bypass_o = cg_reg[`NCR_CG_BYPASS];
	assign cg_jtag_boot_o = cg_reg[`NCR_CG_JTAG];
	assign tile_reset_o = (cg_state_reg == NCR_CG_RESET);
	assign cg_busy_o = (cg_state_reg != NCR_CG_IDLE);

	// Direction lookup against the live tables
	ncr_route u_route
	(
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.node_id_i(node_id_reg),
		.dir_lo_i(dir_lo_reg),
		.dir_hi_i(dir_hi_reg),
		.link_dirs_i(link_dirs_reg),
		.pkt_valid_i(pkt_valid_i),
		.pkt_dest_i(pkt_dest_i),
		.route_valid_o(route_valid_o),
		.route_local_o(route_local_o),
		.route_dir_o(route_dir_o),
		.link_eligible_o(link_eligible_o)
	);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i || !ce_i);

	property p_wlock;
		cfg_wr_i && wlock_reg && cfg_addr_i == `NCR_A_NODE_ID |=> $stable(node_id_o);
	endproperty
	a_wlock: assert property (p_wlock) else $error("locked node id changed");

	property p_cglock;
		cfg_wr_i && cglock_reg && cfg_addr_i == `NCR_A_CLKGEN |=> $stable(cg_fb_mul_o) && !tile_reset_o;
	endproperty
	a_cglock: assert property (p_cglock) else $error("locked clock settings changed");

	property p_hdr;
		wr_ok && cfg_addr_i == `NCR_A_SW_CFG |=> hdr_one_byte_o == $past(cfg_wdata_i[0]);
	endproperty
	a_hdr: assert property (p_hdr) else $error("header mode not taken");

	property p_node_rd;
		cfg_rd_i && cfg_addr_i == `NCR_A_NODE_ID |=> cfg_rvalid_o && cfg_rdata_o == {16'h0000, node_id_o};
	endproperty
	a_node_rd: assert property (p_node_rd) else $error("node id readback wrong");

	property p_tile_rst;
		cg_wr && !cfg_wdata_i[`NCR_CG_NORST] |=> tile_reset_o[*8] ##1 !tile_reset_o;
	endproperty
	a_tile_rst: assert property (p_tile_rst) else $error("tile reset length wrong");

	property p_norst;
		cg_wr && cfg_wdata_i[`NCR_CG_NORST] |=> !tile_reset_o [*3];
	endproperty
	a_norst: assert property (p_norst) else $error("suppressed reset occurred");

	property p_nolock;
		cg_wr && cfg_wdata_i[`NCR_CG_NORST] && cfg_wdata_i[`NCR_CG_NOLOCK] |=> !cg_busy_o;
	endproperty
	a_nolock: assert property (p_nolock) else $error("waited for relock");

	property p_bypass;
		cg_wr |=> cg_bypass_o == $past(cfg_wdata_i[29]) && cg_jtag_boot_o == $past(cfg_wdata_i[28]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass or boot mode wrong");

	property p_divs;
		cg_wr |=> cg_out_div_o == $past(cfg_wdata_i[25:23]) && cg_in_div_o == $past(cfg_wdata_i[6:0]);
	endproperty
	a_divs: assert property (p_divs) else $error("divider fields wrong");

	property p_usercode;
		cfg_rd_i && cfg_addr_i == `NCR_A_USERCODE |=> cfg_rdata_o[17:0] == METAL_ID;
	endproperty
	a_usercode: assert property (p_usercode) else $error("metal id wrong");

	c_tile_rst: cover property (cg_wr ##1 tile_reset_o ##8 cg_busy_o);
	c_lock_reject: cover property (cfg_wr_i && wlock_reg);
	c_local: cover property (route_valid_o && route_local_o);
endmodule : ncr_cfg

// ==== sim/test_node_config_routing_regs.sv ====
// Purpose: Self-checking bench for the node configuration register bank
// Assumes: Register numbers and masks come from ncr_regs.svh; ce_i high except one test
// Notes: Drivers queue expected results; a monitor compares when a result pulses
`timescale 1ns/1ps
`include "ncr_regs.svh"
module test_node_config_routing_regs;
	import ncr_pkg::*;
	localparam logic [7:0] REV = 8'h5A; // Arbitrary value
	localparam logic [7:0] VER = 8'hC3; // Arbitrary value
	localparam logic [7:0] LNK = 8'h06;
	localparam logic [7:0] SPR = 8'h03;
	localparam logic [7:0] DPR = 8'h05;
	localparam logic [31:0] SID = 32'h1234_5679; // Arbitrary value
	localparam logic [17:0] MID = 18'h2A5C3; // Arbitrary value
	// Stimulus
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, lock = 1'b0, pv = 1'b0;
	logic [7:0] addr = 8'h00, boot = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [13:0] otp = 14'h0;
	ncr_node_id_t pd = 16'h0;
	// Observed
	logic [31:0] rdata;
	logic rvalid, byp, jtb, busy, trst, hdr, rv, rl;
	logic [2:0] od;
	logic [12:0] fb;
	logic [6:0] idv;
	ncr_node_id_t nid;
	logic [15:0] swd, rfd;
	ncr_dir_t rdir;
	logic [7:0] elig;
	// Bench model and bookkeeping
	logic [31:0] rq[$];
	logic [12:0] pq[$];
	logic [31:0] dlo, dhi, d, v;
	ncr_dir_t ldir[8];
	ncr_node_id_t my_id;
	int error_cnt = 0;
	int total_checks = 0;
	int rcnt = 0;
	// Register lists walked by the read-only and reset-value scenarios
	logic [7:0] ro_nums[4] = '{8'h00, 8'h01, 8'h09, 8'h0A};
	logic [7:0] rst_nums[8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0C, 8'h0D, 8'h02};

	always #2 clk = ~clk;

	ncr_cfg #(.SW_REVISION(REV), .SW_VERSION(VER), .NUM_SYS_LINKS(LNK), .NUM_SW_PROCS(SPR),
		.NUM_DEV_PROCS(DPR), .SCAN_DEVICE_ID(SID), .METAL_ID(MID)) u_ncr_cfg
	(
		.clock_i(clk), .rstn_i(rstn), .ce_i(ce), .cfg_wr_i(wr), .cfg_rd_i(rd),
		.cfg_addr_i(addr), .cfg_wdata_i(wd), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
		.boot_select_pins_i(boot), .otp_user_code_i(otp), .cg_locked_i(lock),
		.cg_out_div_o(od), .cg_fb_mul_o(fb), .cg_in_div_o(idv), .cg_bypass_o(byp),
		.cg_jtag_boot_o(jtb), .cg_busy_o(busy), .tile_reset_o(trst), .hdr_one_byte_o(hdr),
		.node_id_o(nid), .sw_clk_div_o(swd), .ref_clk_div_o(rfd), .pkt_valid_i(pv),
		.pkt_dest_i(pd), .route_valid_o(rv), .route_local_o(rl), .route_dir_o(rdir),
		.link_eligible_o(elig)
	);

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// One access per cycle; strobes stay up between calls so back-to-back needs no gap
	task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] e);
		wr = w;
		rd = r;
		addr = a;
		wd = e;
		if (r)
			rq.push_back(e);
		@(negedge clk);
	endtask : acc

	task automatic idle;
		wr = 1'b0;
		rd = 1'b0;
		pv = 1'b0;
		@(negedge clk);
	endtask : idle

	task automatic rst(input logic [7:0] b);
		rstn = 1'b0;
		boot = b;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		my_id = '0;
		dlo = '0;
		dhi = '0;
		ldir = '{default: '0};
	endtask : rst

	// Expected {local, direction, eligible links} from the bench's copy of the tables
	function automatic logic [12:0] xroute(input ncr_node_id_t dst);
		logic [15:0] x;
		logic [3:0] dr;
		logic [7:0] el;
		x = dst ^ my_id;
		dr = 4'h0;
		if (x == 16'h0)
			return 13'h1000;
		for (int p = 0; p < 16; p++)
			if (x[p])
				dr = (p < 8) ? dlo[4*p +: 4] : dhi[4*(p-8) +: 4];
		for (int n = 0; n < 8; n++)
			el[n] = (ldir[n] == dr);
		return {1'b0, dr, el};
	endfunction : xroute

	// Clock-generator write with lock held low, then, unless reset and relock are both suppressed, a refused write while busy
	task automatic cgw(input logic [31:0] c);
		rcnt = 0;
		acc(1'b1, 1'b0, `NCR_A_CLKGEN, c);
		if (!(c[31] && c[30]))
			acc(1'b1, 1'b0, `NCR_A_CLKGEN, ~c);
		idle();
		repeat (12) @(negedge clk);
		chk("tile_reset_len", rcnt, c[31] ? 0 : `NCR_TILE_RST_CYC);
		chk("busy", {31'h0, busy}, {31'h0, ~c[30]});
		chk("cg_fields", {7'h0, byp, jtb, od, fb, idv}, {7'h0, c[29:28], c[25:23], c[20:8], c[6:0]});
		acc(1'b0, 1'b1, `NCR_A_CLKGEN, c & `NCR_CG_WMASK);
		lock = 1'b1;
		idle();
		@(negedge clk);
		chk("busy_after_lock", {31'h0, busy}, 32'h0);
		lock = 1'b0;
	endtask : cgw

	// Tile reset high cycles are counted apart from the main sequence
	always @(negedge clk)
		if (trst === 1'b1)
			rcnt++;

	// Result monitor takes the oldest note whenever an answer pulses
	always @(negedge clk)
	begin
		if (rvalid === 1'b1)
			chk("rdata", rdata, (rq.size() > 0) ? rq.pop_front() : 32'hDEAD_0BAD);
		if (rv === 1'b1)
			chk("route", {19'h0, rl, rdir, elig}, (pq.size() > 0) ? {19'h0, pq.pop_front()} : '1);
	end

	// Watchdog well beyond the few hundred cycles the sequence needs
	initial
	begin
		#100000;
		error_cnt++;
		end_sim();
	end

	initial
	begin
		void'($urandom(32'h003f826d));
		@(negedge clk);
		rst(8'hA5);
		boot = 8'h3C;
		otp = 14'($urandom);
		rq.delete();
		// Writes to read-only numbers must leave them alone
		foreach (ro_nums[i])
			acc(1'b1, 1'b0, ro_nums[i], 32'hFFFF_FFFF);
		acc(1'b0, 1'b1, `NCR_A_DEV_ID, {8'h00, 8'hA5, REV, VER});
		acc(1'b0, 1'b1, `NCR_A_SW_DESC, {8'h00, LNK, SPR, DPR});
		acc(1'b0, 1'b1, `NCR_A_SCAN_ID, SID);
		acc(1'b0, 1'b1, `NCR_A_USERCODE, {otp, MID});
		// Reset values, unmapped number 0x02 last
		foreach (rst_nums[i])
			acc(1'b0, 1'b1, rst_nums[i],
				(i == 4) ? 32'h3 : 32'h0);
		// Read/write words, each read straight after its write except the direction tables
		d = $urandom;
		my_id = d[15:0];
		acc(1'b1, 1'b0, `NCR_A_NODE_ID, d);
		acc(1'b0, 1'b1, `NCR_A_NODE_ID, {16'h0, d[15:0]});
		chk("node_id", {16'h0, nid}, {16'h0, my_id});
		d = $urandom;
		acc(1'b1, 1'b0, `NCR_A_SW_DIV, d);
		acc(1'b0, 1'b1, `NCR_A_SW_DIV, {16'h0, d[15:0]});
		chk("sw_div", {16'h0, swd}, {16'h0, d[15:0]});
		d = $urandom;
		acc(1'b1, 1'b0, `NCR_A_REF_DIV, d);
		acc(1'b0, 1'b1, `NCR_A_REF_DIV, {16'h0, d[15:0]});
		chk("ref_div", {16'h0, rfd}, {16'h0, d[15:0]});
		dlo = $urandom;
		dhi = $urandom;
		acc(1'b1, 1'b0, `NCR_A_DIR_LO, dlo);
		// Write and read in one cycle: the read returns the value before the write
		wr = 1'b1;
		rd = 1'b1;
		addr = `NCR_A_DIR_HI;
		wd = dhi;
		rq.push_back(32'h0);
		@(negedge clk);
		acc(1'b0, 1'b1, `NCR_A_DIR_LO, dlo);
		acc(1'b0, 1'b1, `NCR_A_DIR_HI, dhi);
		for (int n = 0; n < 8; n++)
		begin
			d = $urandom;
			ldir[n] = d[11:8];
			acc(1'b1, 1'b0, 8'(`NCR_A_LINK_BASE * 8 + n), d);
			acc(1'b0, 1'b1, 8'(`NCR_A_LINK_BASE * 8 + n), {20'h0, d[11:8], 8'h00});
		end
		// Packets every cycle: each mismatch position, a local hit, then random ones
		idle();
		for (int i = 0; i < 48; i++)
		begin
			pd = (i < 16) ? (my_id ^ (16'h1 << i) ^ (16'($urandom) & ((16'h1 << i) - 16'h1)))
				: ((i == 16) ? my_id : 16'($urandom));
			pv = 1'b1;
			pq.push_back(xroute(pd));
			@(negedge clk);
		end
		idle();
		// Header size, then clock-generator write lock
		acc(1'b1, 1'b0, `NCR_A_SW_CFG, 32'h0000_0001);
		acc(1'b0, 1'b1, `NCR_A_SW_CFG, 32'h0000_0001);
		chk("hdr_one_byte", {31'h0, hdr}, 32'h1);
		acc(1'b1, 1'b0, `NCR_A_SW_CFG, 32'h0000_0100);
		rcnt = 0;
		acc(1'b1, 1'b0, `NCR_A_CLKGEN, $urandom);
		idle();
		repeat (10) @(negedge clk);
		chk("locked_cg_reset", rcnt, 0);
		acc(1'b0, 1'b1, `NCR_A_CLKGEN, 32'h0);
		acc(1'b1, 1'b0, `NCR_A_SW_CFG, 32'h0);
		idle();
		// All four combinations of reset suppress and relock skip
		for (int k = 0; k < 4; k++)
		begin
			v = $urandom;
			v[31:30] = 2'(k);
			cgw(v);
		end
		// Clock enable low freezes a write
		ce = 1'b0;
		acc(1'b1, 1'b0, `NCR_A_NODE_ID, {16'h0, ~my_id});
		ce = 1'b1;
		acc(1'b0, 1'b1, `NCR_A_NODE_ID, {16'h0, my_id});
		// Write lock blocks everything, itself included, until reset
		acc(1'b1, 1'b0, `NCR_A_SW_CFG, 32'h8000_0001);
		acc(1'b1, 1'b0, `NCR_A_NODE_ID, {16'h0, ~my_id});
		acc(1'b1, 1'b0, `NCR_A_SW_CFG, 32'h0);
		acc(1'b0, 1'b1, `NCR_A_SW_CFG, 32'h8000_0001);
		acc(1'b0, 1'b1, `NCR_A_NODE_ID, {16'h0, my_id});
		idle();
		rst(8'h5C);
		acc(1'b0, 1'b1, `NCR_A_SW_CFG, 32'h0);
		acc(1'b0, 1'b1, `NCR_A_DEV_ID, {8'h00, 8'h5C, REV, VER});
		idle();
		repeat (4) @(negedge clk);
		chk("pending", 32'(rq.size() + pq.size()), 32'h0);
		end_sim();
	end
endmodule : test_node_config_routing_regs
